/* design/uatx_consts.vh */
`ifndef UATX_CONSTS_VH
`define UATX_CONSTS_VH
// ----------------------------------------
// mode register field positions
// ----------------------------------------
`define UATX_MODE_W        6
`define UATX_MODE_CHR8     0
`define UATX_MODE_PAR_LO   1
`define UATX_MODE_PAR_HI   2
`define UATX_MODE_STOP2    3
`define UATX_MODE_RSV_LO   4
`define UATX_MODE_RSV_HI   5
// ----------------------------------------
// parity encodings and reset values
// ----------------------------------------
`define UATX_PAR_NONE      2'h0
`define UATX_PAR_ZERO      2'h1
`define UATX_PAR_ODD       2'h2
`define UATX_PAR_EVEN      2'h3
`define UATX_MODE_RST      6'h00
`define UATX_DATA_RST      8'hff
// ----------------------------------------
// timing
// ----------------------------------------
`define UATX_BAUD_DIV_RST  16'h0364
`endif

/* design/uatx_baud_gen.v */
`timescale 1ns/100ps
`include "uatx_consts.vh"
// ----------------------------------------
// bit-period enable divider
// ----------------------------------------
module uatx_baud_gen #(
   parameter DIV_W = 16
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             run,
   input  wire [DIV_W-1:0] divisor,
   output reg              bit_tick
);
   reg [DIV_W-1:0] cnt_reg;
   reg [DIV_W-1:0] cnt_next;
   reg             tick_next;

   always @* begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (!run) begin
         cnt_next = {DIV_W{1'b0}};
      end else if (cnt_reg >= divisor - {{(DIV_W-1){1'b0}}, 1'b1} || divisor == {DIV_W{1'b0}}) begin
         cnt_next  = {DIV_W{1'b0}};
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg  <= {DIV_W{1'b0}};
         bit_tick <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         bit_tick <= tick_next;
      end
   end
endmodule

/* design/uatx_tx_path.v */
`timescale 1ns/100ps
`include "uatx_consts.vh"
// ----------------------------------------
// Overview of operation
// - frame: start, data, optional parity, stops
// - length, parity, stop length from mode
// - data bits leave lsb first after start
// - unit enable drives line idle high
// - tx enable one means enabled, zero disabled
// - write when enabled loads holding buffer
// - start, parity, stop bits generated internally
// - done pulse with final stop bit output
// - nothing pending at end: stop, idle
// - reset-emptied shift register raises no done
// - buffer frees when shifting starts
// - pending flag one while byte waits
// - flags pass 10, 11, 01 in streaming
// - active flag one during frame transmission
// - flags 00 at start; first write sequence
// - writes while disabled are discarded
// - clearing either enable clears both flags
// ----------------------------------------
module uatx_tx_path #(
   parameter DIV_W = 16
) (
   input  wire                     clk,
   input  wire                     rst_n,
   input  wire [`UATX_MODE_W-1:0]  uart_mode_reg,
   input  wire                     uart_unit_enable,
   input  wire                     tx_enable_bit,
   input  wire [DIV_W-1:0]         baud_divisor,
   input  wire                     tx_wr_strobe,
   input  wire [7:0]               tx_wr_data,
   output wire [7:0]               tx_holding_buffer,
   output wire [1:0]               tx_status_reg,
   output wire                     tx_buffer_pending,
   output wire                     tx_shift_active,
   output reg                      tx_done_irq,
   output reg                      serial_out_pin
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE  = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_DATA  = 3'h2;
   localparam ST_PAR   = 3'h3;
   localparam ST_STOP  = 3'h4;

   reg  [2:0] state_reg;
   reg  [2:0] state_next;
   reg  [7:0] hold_reg;
   reg  [7:0] hold_next;
   reg  [7:0] shift_reg;
   reg  [7:0] shift_next;
   reg        pend_reg;
   reg        pend_next;
   reg        act_reg;
   reg        act_next;
   reg  [2:0] bitcnt_reg;
   reg  [2:0] bitcnt_next;
   reg        stopcnt_reg;
   reg        stopcnt_next;
   reg        par_reg;
   reg        par_next;
   reg        line_next;
   reg        done_next;
   reg        load_now;
   reg        frame_over;
   wire       enabled;
   wire       bit_tick;
   wire       chr8;
   wire [1:0] par_mode;
   wire       stop2;
   wire [2:0] last_bit;
   wire [7:0] char_mask;
   wire [8:0] par_chain;
   wire       char_par;
   genvar     gi;

   // ----------------------------------------
   // mode decode and status
   // ----------------------------------------
   assign enabled           = uart_unit_enable & tx_enable_bit;
   assign chr8              = uart_mode_reg[`UATX_MODE_CHR8];
   assign par_mode          = uart_mode_reg[`UATX_MODE_PAR_HI:`UATX_MODE_PAR_LO];
   assign stop2             = uart_mode_reg[`UATX_MODE_STOP2];
   assign last_bit          = chr8 ? 3'h7 : 3'h6;
   assign tx_buffer_pending = pend_reg;
   assign tx_shift_active   = act_reg;
   assign tx_status_reg     = {pend_reg, act_reg};
   assign tx_holding_buffer = hold_reg;
   assign char_mask         = {chr8, 7'h7f};
   assign char_par          = par_chain[8];

   // ----------------------------------------
   // character parity
   // ----------------------------------------
   // taken from the buffer at load time, so the shifter needs no parity tap
   assign par_chain[0] = 1'b0;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_par
         assign par_chain[gi+1] = par_chain[gi] ^ (hold_reg[gi] & char_mask[gi]);
      end
   endgenerate

   // ----------------------------------------
   // bit timing
   // ----------------------------------------
   // divider restarts with each frame started from idle so the start bit lasts a full period
   uatx_baud_gen #(
      .DIV_W    (DIV_W)
   ) u_baud (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      (state_reg != ST_IDLE),
      .divisor  (baud_divisor),
      .bit_tick (bit_tick)
   );

   // ----------------------------------------
   // holding buffer and flags
   // ----------------------------------------
   always @* begin
      hold_next = hold_reg;
      pend_next = pend_reg;
      act_next  = act_reg;
      if (!enabled) begin
         pend_next = 1'b0;
         act_next  = 1'b0;
      end else begin
         if (load_now) begin
            pend_next = 1'b0;
            act_next  = 1'b1;
         end
         if (frame_over) begin
            act_next = 1'b0;
         end
         // a write landing with a transfer keeps the flag set
         if (tx_wr_strobe) begin
            hold_next = tx_wr_data;
            pend_next = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   always @* begin
      state_next   = state_reg;
      shift_next   = shift_reg;
      bitcnt_next  = bitcnt_reg;
      stopcnt_next = stopcnt_reg;
      par_next     = par_reg;
      line_next    = serial_out_pin;
      done_next    = 1'b0;
      load_now     = 1'b0;
      frame_over   = 1'b0;
      if (!enabled) begin
         state_next = ST_IDLE;
         line_next  = 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               line_next = 1'b1;
               if (pend_reg) begin
                  // transfer to shift register frees the buffer
                  shift_next = hold_reg;
                  par_next   = char_par;
                  load_now   = 1'b1;
                  state_next = ST_START;
                  line_next  = 1'b0;
               end
            end
            ST_START: begin
               if (bit_tick) begin
                  state_next  = ST_DATA;
                  bitcnt_next = 3'h0;
                  line_next   = shift_reg[0];
                  shift_next  = {1'b1, shift_reg[7:1]};
               end
            end
            ST_DATA: begin
               if (bit_tick) begin
                  if (bitcnt_reg == last_bit) begin
                     stopcnt_next = 1'b0;
                     if (par_mode != `UATX_PAR_NONE) begin
                        state_next = ST_PAR;
                        case (par_mode)
                           `UATX_PAR_ODD:  line_next = ~par_reg;
                           `UATX_PAR_EVEN: line_next = par_reg;
                           default:        line_next = 1'b0;
                        endcase
                     end else begin
                        state_next = ST_STOP;
                        line_next  = 1'b1;
                        done_next  = ~stop2;
                     end
                  end else begin
                     bitcnt_next = bitcnt_reg + 3'h1;
                     line_next   = shift_reg[0];
                     shift_next  = {1'b1, shift_reg[7:1]};
                  end
               end
            end
            ST_PAR: begin
               if (bit_tick) begin
                  state_next = ST_STOP;
                  line_next  = 1'b1;
                  done_next  = ~stop2;
               end
            end
            ST_STOP: begin
               if (bit_tick) begin
                  if (stop2 && !stopcnt_reg) begin
                     stopcnt_next = 1'b1;
                     done_next    = 1'b1;
                  end else if (pend_reg) begin
                     // next byte waiting: back-to-back frame
                     shift_next = hold_reg;
                     par_next   = char_par;
                     load_now   = 1'b1;
                     state_next = ST_START;
                     line_next  = 1'b0;
                  end else begin
                     frame_over = 1'b1;
                     state_next = ST_IDLE;
                     line_next  = 1'b1;
                  end
               end
            end
            default: begin
               state_next = ST_IDLE;
               line_next  = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         pend_reg  <= 1'b0;
         act_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         pend_reg  <= pend_next;
         act_reg   <= act_next;
      end
   end

   // ----------------------------------------
   // holding buffer register
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         hold_reg <= `UATX_DATA_RST;
      end else begin
         hold_reg <= hold_next;
      end
   end

   // ----------------------------------------
   // shifter registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         shift_reg   <= `UATX_DATA_RST;
         bitcnt_reg  <= 3'h0;
         stopcnt_reg <= 1'b0;
         par_reg     <= 1'b0;
      end else begin
         shift_reg   <= shift_next;
         bitcnt_reg  <= bitcnt_next;
         stopcnt_reg <= stopcnt_next;
         par_reg     <= par_next;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   // line and done leave from flops so the pin never glitches
   always @(posedge clk) begin
      if (!rst_n) begin
         serial_out_pin <= 1'b1;
         tx_done_irq    <= 1'b0;
      end else begin
         serial_out_pin <= line_next;
         tx_done_irq    <= done_next;
      end
   end
endmodule

/* verif/uatx_tx_asserts.sv */
`timescale 1ns/100ps
// ----------------
// transmit path checks
// ----------------
module uatx_tx_asserts (
   input wire       clk,
   input wire       rst_n,
   input wire       uart_unit_enable,
   input wire       tx_enable_bit,
   input wire       tx_wr_strobe,
   input wire [1:0] tx_status_reg,
   input wire       tx_buffer_pending,
   input wire       tx_shift_active,
   input wire       tx_done_irq,
   input wire       serial_out_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire en = uart_unit_enable && tx_enable_bit;
   property p_pair; tx_status_reg == {tx_buffer_pending, tx_shift_active}; endproperty
   a_pair: assert property (p_pair) else $error("status pair mismatch");
   property p_idle; !tx_shift_active |-> serial_out_pin; endproperty
   a_idle: assert property (p_idle) else $error("line low while idle");
   property p_off; !en |=> !tx_buffer_pending && !tx_shift_active && serial_out_pin; endproperty
   a_off: assert property (p_off) else $error("disable did not clear");
   property p_noirq; !en |=> !tx_done_irq; endproperty
   a_noirq: assert property (p_noirq) else $error("done pulse after disable");
   property p_take; tx_wr_strobe && en |=> tx_buffer_pending; endproperty
   a_take: assert property (p_take) else $error("write not taken");
   property p_start; $rose(tx_shift_active) |-> $fell(tx_buffer_pending) && !serial_out_pin; endproperty
   a_start: assert property (p_start) else $error("bad first start");
   property p_irq; tx_done_irq |-> tx_shift_active && serial_out_pin ##1 !tx_done_irq; endproperty
   a_irq: assert property (p_irq) else $error("bad done pulse");
   property p_xfer; $fell(tx_buffer_pending) && $past(en) |-> tx_shift_active && !serial_out_pin; endproperty
   a_xfer: assert property (p_xfer) else $error("transfer without start");
   c_start: cover property ($rose(tx_shift_active));
   c_irq: cover property (tx_done_irq);
   c_stream: cover property (tx_buffer_pending && tx_shift_active);
endmodule
bind uatx_tx_path uatx_tx_asserts uatx_tx_asserts_i (.clk(clk), .rst_n(rst_n),
   .uart_unit_enable(uart_unit_enable), .tx_enable_bit(tx_enable_bit), .tx_wr_strobe(tx_wr_strobe),
   .tx_status_reg(tx_status_reg), .tx_buffer_pending(tx_buffer_pending), .tx_shift_active(tx_shift_active),
   .tx_done_irq(tx_done_irq), .serial_out_pin(serial_out_pin));

/* verif/uatx_rx_model.sv */
`timescale 1ns/100ps
// ----------------
// remote receiver, samples near mid-bit
// ----------------
module uatx_rx_model (
   input wire        clk,
   input wire        line,
   input wire [5:0]  mode,
   input wire [15:0] div,
   output reg [7:0]  rx_data,
   output reg        rx_par,
   output reg        rx_stop_ok,
   output integer    rx_count
);
   integer k;
   initial begin
      rx_count = 0;
      forever begin
         @(negedge clk);
         if (line === 1'b0) begin
            repeat (div / 2) @(negedge clk);
            rx_data = 8'h00;
            for (k = 0; k < 7 + mode[0]; k = k + 1) begin
               repeat (div) @(negedge clk);
               rx_data[k] = line;
            end
            rx_par = 1'b0;
            if (mode[2:1] != 2'h0) begin
               repeat (div) @(negedge clk);
               rx_par = line;
            end
            rx_stop_ok = 1'b1;
            for (k = 0; k <= mode[3]; k = k + 1) begin
               repeat (div) @(negedge clk);
               rx_stop_ok = rx_stop_ok & line;
            end
            rx_count = rx_count + 1;
         end
      end
   end
endmodule

/* verif/test_uart_transmit_path.sv */
`timescale 1ns/100ps
// ----------------
// transmit path bench
// ----------------
module test_uart_transmit_path;
   reg         clk, rst_n, unit_en, tx_en, strobe;
   reg  [5:0]  mode;
   reg  [15:0] div;
   reg  [7:0]  wdata;
   wire [7:0]  hold, rx_data;
   wire [1:0]  status;
   wire        pend, act, irq, line, rx_par, rx_stop_ok;
   wire [31:0] rx_count;
   integer     irqs, num_errors, num_checks, i;
   uatx_tx_path uatx_tx_path_i (.clk(clk), .rst_n(rst_n), .uart_mode_reg(mode), .uart_unit_enable(unit_en),
      .tx_enable_bit(tx_en), .baud_divisor(div), .tx_wr_strobe(strobe), .tx_wr_data(wdata),
      .tx_holding_buffer(hold), .tx_status_reg(status), .tx_buffer_pending(pend), .tx_shift_active(act),
      .tx_done_irq(irq), .serial_out_pin(line));
   uatx_rx_model uatx_rx_model_i (.clk(clk), .line(line), .mode(mode), .div(div), .rx_data(rx_data),
      .rx_par(rx_par), .rx_stop_ok(rx_stop_ok), .rx_count(rx_count));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input [7:0] b);
      begin
         strobe = 1'b1;
         wdata = b;
         tick(1);
         strobe = 1'b0;
      end
   endtask
   task t_frame(input [5:0] m, input [15:0] v, input [7:0] b);
      reg [7:0] d;
      integer n, c0, q0;
      begin
         mode = m;
         div = v;
         d = m[0] ? b : {1'b0, b[6:0]};
         c0 = rx_count;
         q0 = irqs;
         wr(b);
         chk({hold, status}, {b, 2'h2});
         tick(1);
         chk({status, line}, 3'h2);
         for (n = 0; n < 400 && irq !== 1'b1; n = n + 1) tick(1);
         chk(n, 1 + (8 + m[0] + (m[2:1] != 2'h0) + m[3]) * v);
         for (n = 0; n < 400 && act !== 1'b0; n = n + 1) tick(1);
         chk({line, irqs}, {1'b1, q0 + 1});
         chk(rx_count, c0 + 1);
         chk({rx_data, rx_par, rx_stop_ok}, {d, m[2:1] == 2'h3 ? ^d : (m[2:1] == 2'h2 ? ~^d : 1'b0), 1'b1});
         $display("frame test done, mode %h", m);
      end
   endtask
   task t_stream;
      integer n, c0;
      begin
         mode = 6'h01;
         div = 16'h0004;
         c0 = rx_count;
         wr(8'h3c);
         tick(1);
         chk(status, 2'h1);
         wr(8'hc3);
         chk(status, 2'h3);
         for (n = 0; n < 400 && pend !== 1'b0; n = n + 1) tick(1);
         chk({status, line}, 3'h2);
         for (n = 0; n < 400 && act !== 1'b0; n = n + 1) tick(1);
         chk({rx_count, rx_data}, {c0 + 2, 8'hc3});
         $display("stream test done");
      end
   endtask
   task t_off(input integer sel);
      integer q0;
      begin
         mode = 6'h00;
         wr(8'h55);
         tick(8);
         q0 = irqs;
         unit_en = (sel != 1);
         tx_en = (sel != 0);
         rst_n = (sel != 2);
         tick(1);
         chk({status, line}, 3'h1);
         wr(8'ha5);
         tick(60);
         chk({hold, status}, {(sel == 2) ? 8'hff : 8'h55, 2'h0});
         chk(irqs, q0);
         unit_en = 1'b1;
         tx_en = 1'b1;
         rst_n = 1'b1;
         tick(1);
         $display("disable test done, %0d", sel);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d, mismatches %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #200000;
      num_errors = num_errors + 1;
      conclude;
   end
   initial begin
      rst_n = 1'b0;
      unit_en = 1'b1;
      tx_en = 1'b1;
      strobe = 1'b0;
      wdata = 8'h00;
      mode = 6'h00;
      div = 16'h0004;
      irqs = 0;
      num_errors = 0;
      num_checks = 0;
      tick(20);
      rst_n = 1'b1;
      chk({hold, status, line}, 11'h7f9);
      for (i = 0; i < 16; i = i + 1) t_frame({2'h0, i[3:0]}, 16'h0004, 8'ha7 ^ i[7:0]);
      t_frame(6'h0b, 16'h0007, 8'h81);
      t_stream;
      t_off(0);
      t_off(1);
      t_off(2);
      t_frame(6'h06, 16'h0004, 8'h5a);
      conclude;
   end
endmodule
